// ==== verilog/cfp_top.sv ====
/*
  cfp_top: pointer and status logic of the CAN FD message fifos: event log
  flags, user addresses of seven general fifos, event log and queue.
  Assumes: message engine step pulses on the system clock; software on a
  plain register port with read data one cycle after the read strobe.
*/
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps


module cfp_top
  import cfp_pkg::*;
#(
  parameter logic [31:0] ELEM_BYTES = CFP_ELEM_BYTES
)
(
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic [CFP_ADDR_W-1:0] reg_addr,
  input  wire logic [CFP_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [CFP_UNITS-1:0]  hw_step,
  output logic [CFP_DATA_W-1:0]      reg_rdata,
  output logic                       event_log_irq
);

  // ==========================================================================
  // software visible state
  // ==========================================================================
  logic [3:0]     irq_en_r;             // overflow, full, half, not empty enables
  logic [31:0]    ram_base_r;           // message ram base
  logic           event_log_overflow_flag_r; // sticky overflow flag
  logic [15:0]    rdata_r;              // read data register
  logic           irq_r;                // registered interrupt request
  logic [15:0]    rdata_nxt;            // read mux

  // ==========================================================================
  // per unit wiring
  // ==========================================================================
  cfp_unit_cfg_s  cfg_r   [CFP_UNITS];  // depth and direction per unit
  cfp_unit_cfg_s  cfg_eff [CFP_UNITS];  // direction forced where fixed
  logic [31:0]    head_a  [CFP_UNITS];  // head user address
  logic [31:0]    tail_a  [CFP_UNITS];  // tail user address
  logic [31:0]    user_a  [CFP_UNITS];  // reported user address
  cfp_occ_s       occ     [CFP_UNITS];  // occupancy flags
  logic [CFP_UNITS-1:0] ovf;            // overflow pulses
  logic [CFP_UNITS-1:0] sw_step;        // software advance pulses
  logic [CFP_UNITS-1:0] flush;          // software unit reset pulses

  // event log flag word, bits above 3 are unimplemented
  logic [3:0]     event_log_flags;
  logic           event_log_full_flag;
  logic           event_log_half_flag;
  logic           event_log_nonempty_flag;

  genvar u;
  generate
    for (u = 0; u < CFP_UNITS; u = u + 1)
    begin : g_unit
      // config register, written whole
      always_ff @(posedge clk_sys)
      begin
        if (reset)
        begin
          cfg_r[u].depth  <= CFP_RST_DEPTH;
          cfg_r[u].dir_tx <= 1'b0;
        end
        else if (reg_wr && (reg_addr == CFP_CFG_OFF + 6'(u)))
        begin
          cfg_r[u].depth  <= reg_wdata[CFP_DEPTH_LSB +: 5];
          cfg_r[u].dir_tx <= reg_wdata[CFP_DIR_BIT];
        end
      end

      // control bits act in the write cycle and are never stored, so they
      // read back as zero right away
      assign sw_step[u] = reg_wr && (reg_addr == CFP_CTL_OFF + 6'(u))
                          && reg_wdata[CFP_ADV_BIT];
      assign flush[u]   = reg_wr && (reg_addr == CFP_CTL_OFF + 6'(u))
                          && reg_wdata[CFP_RESET_BIT];

      // event log is always filled by hardware, the queue always by software
      if (u == CFP_U_EVLOG)
      begin : g_evlog
        assign cfg_eff[u] = '{depth: cfg_r[u].depth, dir_tx: 1'b0};
        assign user_a[u]  = tail_a[u];
      end
      else if (u == CFP_U_QUEUE)
      begin : g_queue
        assign cfg_eff[u] = '{depth: cfg_r[u].depth, dir_tx: 1'b1};
        assign user_a[u]  = head_a[u];
      end
      else
      begin : g_fifo
        assign cfg_eff[u] = cfg_r[u];
        // transmit: next slot to write; receive: next message to read
        assign user_a[u]  = cfg_r[u].dir_tx ? head_a[u] : tail_a[u];
      end

      // each unit owns a 32-slot window above the ram base
      cfp_ring_ptr #(
        .ELEM_BYTES (ELEM_BYTES)
      ) u_ptr (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .cfg        (cfg_eff[u]),
        .base_addr  (ram_base_r + (32'(u) * CFP_UNIT_SLOTS * ELEM_BYTES)),
        .flush      (flush[u]),
        .hw_step    (hw_step[u]),
        .sw_step    (sw_step[u]),
        .head_addr  (head_a[u]),
        .tail_addr  (tail_a[u]),
        .occ        (occ[u]),
        .overflow   (ovf[u])
      );
    end
  endgenerate

  // ==========================================================================
  // event log status
  // ==========================================================================
  // live occupancy, no storage so a write cannot disturb them
  assign event_log_full_flag     = occ[CFP_U_EVLOG].full;
  assign event_log_half_flag     = occ[CFP_U_EVLOG].half;
  assign event_log_nonempty_flag = occ[CFP_U_EVLOG].nonempty;

  // overflow flag: hardware sets, software clears by writing zero to the
  // bit; a set in the clearing cycle wins so no overflow goes unseen
  always_ff @(posedge clk_sys)
  begin
    if (reset || flush[CFP_U_EVLOG])
      event_log_overflow_flag_r <= 1'b0;
    else if (ovf[CFP_U_EVLOG])
      event_log_overflow_flag_r <= 1'b1;
    else if (reg_wr && (reg_addr == CFP_EVLOG_STATUS_OFF)
             && !reg_wdata[CFP_OVF_BIT])
      event_log_overflow_flag_r <= 1'b0;
  end

  assign event_log_flags = {event_log_overflow_flag_r, event_log_full_flag,
                            event_log_half_flag, event_log_nonempty_flag};

  // ==========================================================================
  // interrupt enables and request
  // ==========================================================================
  // enable register
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      irq_en_r <= CFP_RST_IRQEN;
    else if (reg_wr && (reg_addr == CFP_EVLOG_IRQEN_OFF))
      irq_en_r <= reg_wdata[3:0];
  end

  // one registered request; a flag counts only with its own enable
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      irq_r <= 1'b0;
    else
      irq_r <= |(event_log_flags & irq_en_r);
  end

  // ==========================================================================
  // message ram base
  // ==========================================================================
  // base register halves; changing it moves every reported address at once
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ram_base_r <= CFP_RST_BASE;
    else if (reg_wr && (reg_addr == CFP_RAM_BASE_LO_OFF))
      ram_base_r[15:0] <= reg_wdata;
    else if (reg_wr && (reg_addr == CFP_RAM_BASE_HI_OFF))
      ram_base_r[31:16] <= reg_wdata;
  end

  // ==========================================================================
  // read mux
  // ==========================================================================
  // unmapped and write-only indexes read zero; user addresses are only
  // meaningful outside configuration mode, which software must respect
  always_comb
  begin
    rdata_nxt = CFP_RST_WORD;
    if (reg_addr == CFP_EVLOG_STATUS_OFF)
      rdata_nxt = {12'h000, event_log_flags};
    else if (reg_addr == CFP_EVLOG_IRQEN_OFF)
      rdata_nxt = {12'h000, irq_en_r};
    else if (reg_addr == CFP_RAM_BASE_LO_OFF)
      rdata_nxt = ram_base_r[15:0];
    else if (reg_addr == CFP_RAM_BASE_HI_OFF)
      rdata_nxt = ram_base_r[31:16];
    else
    begin
      for (int i = 0; i < CFP_UNITS; i++)
      begin
        if (reg_addr == CFP_CFG_OFF + 6'(i))
          rdata_nxt = {3'h0, cfg_r[i].depth, cfg_r[i].dir_tx, 7'h00};
        else if (reg_addr == CFP_UA_OFF + 6'(2 * i))
          rdata_nxt = user_a[i][15:0];
        else if (reg_addr == CFP_UA_OFF + 6'(2 * i + 1))
          rdata_nxt = user_a[i][31:16];
      end
    end
  end

  // read data register, updated only on a read strobe so it holds otherwise
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rdata_r <= CFP_RST_WORD;
    else if (reg_rd)
      rdata_r <= rdata_nxt;
  end

  assign reg_rdata     = rdata_r;
  assign event_log_irq = irq_r;

endmodule // cfp_top

// ==== verilog/cfp_pkg.sv ====
/*
  cfp_pkg: shared constants and carriers for the CAN FD FIFO pointer and
  status block (event log FIFO flags, user addresses of all FIFOs).
  Assumes: one system clock, a plain 16-bit register port with word indexes.
*/
package cfp_pkg;

  // ==========================================================================
  // sizes
  // ==========================================================================
  localparam int          CFP_UNITS      = 9;         // event log, queue, 7 fifos
  localparam int          CFP_ADDR_W     = 6;         // register index width
  localparam int          CFP_DATA_W     = 16;        // register data width
  localparam logic [31:0] CFP_ELEM_BYTES = 32'h0000_0048; // default element size
  localparam logic [31:0] CFP_UNIT_SLOTS = 32'h0000_0020; // 32 elements per unit

  // unit numbers inside the pointer array
  localparam int          CFP_U_EVLOG    = 0;         // transmit event log
  localparam int          CFP_U_QUEUE    = 1;         // transmit queue
  localparam int          CFP_U_FIFO1    = 2;         // general fifos 1..7 follow

  // ==========================================================================
  // register indexes
  // ==========================================================================
  localparam logic [5:0]  CFP_EVLOG_STATUS_OFF = 6'h00; // event_log_status
  localparam logic [5:0]  CFP_EVLOG_IRQEN_OFF  = 6'h01; // irq enables
  localparam logic [5:0]  CFP_RAM_BASE_LO_OFF  = 6'h02; // message ram base 15:0
  localparam logic [5:0]  CFP_RAM_BASE_HI_OFF  = 6'h03; // message ram base 31:16
  localparam logic [5:0]  CFP_CFG_OFF          = 6'h10; // unit config, 9 words
  localparam logic [5:0]  CFP_CTL_OFF          = 6'h20; // unit control, 9 words
  // user address lo/hi pairs, 18 words up to 3F; a base of 30 would push the
  // last general fifo past the 6-bit map and alias it onto the status word
  localparam logic [5:0]  CFP_UA_OFF           = 6'h2E; // user address lo/hi pairs

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int          CFP_OVF_BIT    = 3;         // overflow flag
  localparam int          CFP_FULL_BIT   = 2;         // full flag
  localparam int          CFP_HALF_BIT   = 1;         // half full flag
  localparam int          CFP_NEMP_BIT   = 0;         // not empty flag
  localparam int          CFP_DEPTH_LSB  = 8;         // depth field 12:8
  localparam int          CFP_DIR_BIT    = 7;         // direction transmit
  localparam int          CFP_RESET_BIT  = 10;        // unit reset, self clearing
  localparam int          CFP_ADV_BIT    = 8;         // tail_advance, self clearing

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [15:0] CFP_RST_WORD   = 16'h0000;
  localparam logic [3:0]  CFP_RST_IRQEN  = 4'h0;
  localparam logic [31:0] CFP_RST_BASE   = 32'h0000_0000;
  localparam logic [4:0]  CFP_RST_DEPTH  = 5'h00;

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed {
    logic [4:0] depth;       // fifo_depth_field, depth is value plus one
    logic       dir_tx;      // fifo_direction_transmit
  } cfp_unit_cfg_s;

  typedef struct packed {
    logic full;              // occupancy equals depth
    logic half;              // occupancy at least half the depth
    logic nonempty;          // at least one entry held
  } cfp_occ_s;

endpackage

// ==== verilog/cfp_ring_ptr.sv ====
/*
  cfp_ring_ptr: head, tail and occupancy of one message ram ring, with the
  user addresses of both ends.
  Assumes: step pulses are one cycle and come from the system clock domain.
*/
`timescale 1ns/1ps

module cfp_ring_ptr
  import cfp_pkg::*;
#(
  parameter logic [31:0] ELEM_BYTES = CFP_ELEM_BYTES
)
(
  input  wire logic          clk_sys,
  input  wire logic          reset,
  input  wire cfp_unit_cfg_s cfg,
  input  wire logic [31:0]   base_addr,
  input  wire logic          flush,
  input  wire logic          hw_step,
  input  wire logic          sw_step,
  output logic [31:0]        head_addr,
  output logic [31:0]        tail_addr,
  output cfp_occ_s           occ,
  output logic               overflow
);

  // ==========================================================================
  // occupancy
  // ==========================================================================
  logic [4:0] head_r;        // next slot to fill
  logic [4:0] tail_r;        // next slot to drain
  logic [5:0] count_r;       // entries held
  logic [5:0] depth;         // configured depth, 1..32
  logic       prod;          // producer step request
  logic       cons;          // consumer step request
  logic       do_push;
  logic       do_pop;

  assign depth = {1'b0, cfg.depth} + 6'h01;
  // software fills a transmit ring, hardware fills a receive ring
  assign prod  = cfg.dir_tx ? sw_step : hw_step;
  assign cons  = cfg.dir_tx ? hw_step : sw_step;
  // a push into a full ring is dropped; a same-cycle pop does not save it
  assign do_push  = prod && !occ.full;
  assign do_pop   = cons && (count_r != 6'h00);
  assign overflow = prod && occ.full;

  assign occ.full     = (count_r == depth);
  assign occ.half     = ({count_r, 1'b0} >= {1'b0, depth});
  assign occ.nonempty = (count_r != 6'h00);

  // ==========================================================================
  // pointers, wrap after the last element
  // ==========================================================================
  // head pointer
  always_ff @(posedge clk_sys)
  begin
    if (reset || flush)
      head_r <= 5'h00;
    else if (do_push)
      head_r <= (head_r == cfg.depth) ? 5'h00 : head_r + 5'h01;
  end

  // tail pointer
  always_ff @(posedge clk_sys)
  begin
    if (reset || flush)
      tail_r <= 5'h00;
    else if (do_pop)
      tail_r <= (tail_r == cfg.depth) ? 5'h00 : tail_r + 5'h01;
  end

  // entry count
  always_ff @(posedge clk_sys)
  begin
    if (reset || flush)
      count_r <= 6'h00;
    else if (do_push && !do_pop)
      count_r <= count_r + 6'h01;
    else if (do_pop && !do_push)
      count_r <= count_r - 6'h01;
  end

  // addresses step in whole elements from the ring base
  assign head_addr = base_addr + ({27'h0, head_r} * ELEM_BYTES);
  assign tail_addr = base_addr + ({27'h0, tail_r} * ELEM_BYTES);

endmodule // cfp_ring_ptr

// ==== bench/cfp_checker.sv ====
/*
  cfp_checker: port checks of cfp_top with a shadow of the event log.
  Assumes: no push and advance in one cycle; flags read a cycle after a step.
*/
`timescale 1ns/1ps

module cfp_checker
  import cfp_pkg::*;
#(
  parameter logic [31:0] ELEM_BYTES = CFP_ELEM_BYTES
)
(
  input wire logic                  clk_sys,
  input wire logic                  reset,
  input wire logic [CFP_ADDR_W-1:0] reg_addr,
  input wire logic [CFP_DATA_W-1:0] reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [CFP_UNITS-1:0]  hw_step,
  input wire logic [CFP_DATA_W-1:0] reg_rdata,
  input wire logic                  event_log_irq
);
  // ==========================================================================
  // shadow of the event log
  // ==========================================================================
  logic [5:0] cnt_r;   // entries held
  logic [5:0] dep_r;   // depth, field plus one
  logic       ovf_r;   // overflow seen
  logic [3:0] en_r;    // irq enables
  logic       clr;     // unit reset of the event log
  logic [3:0] flags;   // expected status bits 3:0
  assign clr = reg_wr && reg_addr == CFP_CTL_OFF && reg_wdata[CFP_RESET_BIT];
  assign flags = {ovf_r, cnt_r == dep_r, {cnt_r, 1'b0} >= {1'b0, dep_r}, cnt_r != 6'h00};

  // a push into a full log is lost, so the count saturates
  always_ff @(posedge clk_sys)
    if (reset || clr)
      cnt_r <= 6'h00;
    else if (hw_step[CFP_U_EVLOG] && cnt_r != dep_r)
      cnt_r <= cnt_r + 6'h01;
    else if (reg_wr && reg_addr == CFP_CTL_OFF && reg_wdata[CFP_ADV_BIT] && cnt_r != 6'h00)
      cnt_r <= cnt_r - 6'h01;

  // set wins over a clearing write
  always_ff @(posedge clk_sys)
    if (reset || clr)
      ovf_r <= 1'b0;
    else if (hw_step[CFP_U_EVLOG] && cnt_r == dep_r)
      ovf_r <= 1'b1;
    else if (reg_wr && reg_addr == CFP_EVLOG_STATUS_OFF && !reg_wdata[CFP_OVF_BIT])
      ovf_r <= 1'b0;

  // depth and enables follow their writes
  always_ff @(posedge clk_sys)
    if (reset)
    begin
      dep_r <= 6'h01;
      en_r  <= CFP_RST_IRQEN;
    end
    else if (reg_wr && reg_addr == CFP_CFG_OFF)
      dep_r <= {1'b0, reg_wdata[CFP_DEPTH_LSB +: 5]} + 6'h01;
    else if (reg_wr && reg_addr == CFP_EVLOG_IRQEN_OFF)
      en_r <= reg_wdata[3:0];

  // ==========================================================================
  // properties
  // ==========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_status_rd;
    reg_rd && reg_addr == CFP_EVLOG_STATUS_OFF;
  endsequence
  sequence s_ctl_rd;
    reg_rd && reg_addr >= CFP_CTL_OFF && reg_addr < CFP_UA_OFF;
  endsequence

  property p_ovf;  s_status_rd |=> reg_rdata[CFP_OVF_BIT] == $past(flags[3]); endproperty
  property p_full; s_status_rd |=> reg_rdata[CFP_FULL_BIT] == $past(flags[2]); endproperty
  property p_half; s_status_rd |=> reg_rdata[CFP_HALF_BIT] == $past(flags[1]); endproperty
  property p_nemp; s_status_rd |=> reg_rdata[CFP_NEMP_BIT] == $past(flags[0]); endproperty
  property p_upper; s_status_rd |=> reg_rdata[15:4] == 12'h000; endproperty
  property p_ctl; s_ctl_rd |=> reg_rdata == 16'h0000; endproperty
  property p_irq_off; (en_r == 4'h0) [*2] |-> !event_log_irq; endproperty
  property p_irq_mask; ((flags & en_r) == 4'h0) [*3] |-> !event_log_irq; endproperty

  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
  a_full: assert property (p_full) else $error("full flag wrong");
  a_half: assert property (p_half) else $error("half flag wrong");
  a_nemp: assert property (p_nemp) else $error("not-empty flag wrong");
  a_upper: assert property (p_upper) else $error("status upper bits set");
  a_ctl: assert property (p_ctl) else $error("control word reads nonzero");
  a_irq_off: assert property (p_irq_off) else $error("irq with no enable");
  a_irq_mask: assert property (p_irq_mask) else $error("irq from masked flag");
endmodule // cfp_checker

bind cfp_top cfp_checker #(.ELEM_BYTES(ELEM_BYTES)) u_cfp_checker (
  .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .hw_step(hw_step), .reg_rdata(reg_rdata),
  .event_log_irq(event_log_irq));

// ==== bench/cfp_engine_model.sv ====
/*
  cfp_engine_model: message engine stand-in, one step pulse per request.
  Assumes: the bench sends one request at a time on clk_sys.
*/
`timescale 1ns/1ps

module cfp_engine_model
  import cfp_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            reset,
  input  wire logic            go,
  input  wire logic [3:0]      unit,
  input  wire logic [1:0]      delay,
  output logic [CFP_UNITS-1:0] hw_step,
  output logic                 busy
);
  logic       armed_r;  // a step is pending
  logic [1:0] wait_r;   // cycles left, prompt or slow
  logic [3:0] unit_r;   // unit that gets the pulse
  assign busy = armed_r || (hw_step != '0);

  // ==========================================================================
  // one-cycle pulse, never two units at once
  // ==========================================================================
  always_ff @(posedge clk_sys)
    if (reset)
    begin
      armed_r <= 1'b0;
      hw_step <= '0;
    end
    else
    begin
      hw_step <= '0;
      if (go)
      begin
        armed_r <= 1'b1;
        wait_r  <= delay;
        unit_r  <= unit;
      end
      else if (armed_r && wait_r == 2'h0)
      begin
        armed_r         <= 1'b0;
        hw_step[unit_r] <= 1'b1;
      end
      else if (armed_r)
        wait_r <= wait_r - 2'h1;
    end
endmodule // cfp_engine_model

// ==== bench/tb.sv ====
/*
  tb: register and step tests of cfp_top with the engine model.
  Assumes: all nine units have their address pair inside the 6-bit map.
*/
`timescale 1ns/1ps

module tb
  import cfp_pkg::*;
;
  typedef struct packed { logic [5:0] a; logic [15:0] d; } cfp_row_s;
  logic                  clk_sys;
  logic                  reset;
  logic [CFP_ADDR_W-1:0] reg_addr;
  logic [CFP_DATA_W-1:0] reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [CFP_UNITS-1:0]  hw_step;
  logic [CFP_DATA_W-1:0] reg_rdata;
  logic                  event_log_irq;
  logic                  go;
  logic [3:0]            unit;
  logic [1:0]            delay;
  logic                  busy;
  logic [31:0]           base = 32'h0;  // ram base for expectations
  int                    mismatches = 0;
  int                    samples_checked = 0;
  int                    cycles = 0;
  // reads right after reset; base is zero
  cfp_row_s rows [9] = '{'{6'h00, 16'h0000}, '{6'h01, 16'h0000}, '{6'h20, 16'h0000},
    '{6'h04, 16'h0000}, '{6'h2E, 16'h0000}, '{6'h30, 16'h0900}, '{6'h3C, 16'h3F00},
    '{6'h33, 16'h0000}, '{6'h3E, 16'h4800}};

  cfp_top #(.ELEM_BYTES(CFP_ELEM_BYTES)) DUT (.clk_sys(clk_sys), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .hw_step(hw_step), .reg_rdata(reg_rdata), .event_log_irq(event_log_irq));
  cfp_engine_model u_engine (.clk_sys(clk_sys), .reset(reset), .go(go), .unit(unit),
    .delay(delay), .hw_step(hw_step), .busy(busy));

  // ==========================================================================
  // clock, timeout, tasks
  // ==========================================================================
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // whole run needs a few hundred cycles
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches = mismatches + 1;
      results();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // data stands from the cycle after the strobe until the next strobe
  task automatic rd(input logic [5:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 check(reg_rdata, exp, what);
  endtask

  function automatic logic [31:0] ua(input int u, input int idx);
    return base + 32'(u) * CFP_UNIT_SLOTS * CFP_ELEM_BYTES + 32'(idx) * CFP_ELEM_BYTES;
  endfunction

  task automatic rd_ua(input int u, input logic [31:0] exp);
    rd(CFP_UA_OFF + 6'(2 * u), exp[15:0], "address low");
    rd(CFP_UA_OFF + 6'(2 * u + 1), exp[31:16], "address high");
  endtask

  // sampled on the falling edge, clear of the model's updates
  task automatic step(input int u, input logic [1:0] dly);
    @(posedge clk_sys);
    go    <= 1'b1;
    unit  <= 4'(u);
    delay <= dly;
    @(posedge clk_sys);
    go    <= 1'b0;
    @(negedge clk_sys);
    for (int i = 0; i < 8 && busy; i++)
      @(negedge clk_sys);
  endtask

  task automatic reset_rows();
    for (int i = 0; i < 9; i++)
      rd(rows[i].a, rows[i].d, "reset row");
    check(16'(event_log_irq), 16'h0000, "irq after reset");
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    reset <= 1'b1;
    reg_addr <= 6'h00;
    reg_wdata <= 16'h0000;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    go <= 1'b0;
    unit <= 4'h0;
    delay <= 2'h0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    reset_rows();
    base = 32'h0002_1000;
    wr(CFP_RAM_BASE_LO_OFF, base[15:0]);
    wr(CFP_RAM_BASE_HI_OFF, base[31:16]);
    wr(CFP_CFG_OFF, 16'h0300);
    // depth four; the fifth push is lost and marks overflow
    for (int n = 1; n <= 5; n++)
    begin
      step(CFP_U_EVLOG, 2'(n));
      rd(CFP_EVLOG_STATUS_OFF, {12'h000, 1'(n > 4), 1'(n >= 4), 1'(n >= 2), 1'b1}, "fill");
      check(16'(event_log_irq), 16'h0000, "irq masked");
    end
    // zeros on the live flags must not disturb them; only overflow clears
    wr(CFP_EVLOG_STATUS_OFF, 16'h0000);
    rd(CFP_EVLOG_STATUS_OFF, 16'h0007, "after clear");
    wr(CFP_EVLOG_IRQEN_OFF, 16'h0004);
    repeat (3) @(posedge clk_sys);
    #1 check(16'(event_log_irq), 16'h0001, "irq full");
    wr(CFP_EVLOG_IRQEN_OFF, 16'h0008);
    repeat (3) @(posedge clk_sys);
    #1 check(16'(event_log_irq), 16'h0000, "irq ovf off");
    // drain by software; tail steps and wraps
    for (int k = 1; k <= 4; k++)
    begin
      wr(CFP_CTL_OFF, 16'h0100);
      rd_ua(CFP_U_EVLOG, ua(CFP_U_EVLOG, k % 4));
    end
    rd(CFP_EVLOG_STATUS_OFF, 16'h0000, "drained");
    wr(CFP_CFG_OFF + 6'h01, 16'h0100);
    for (int k = 1; k <= 2; k++)
    begin
      wr(CFP_CTL_OFF + 6'h01, 16'h0100);
      rd_ua(CFP_U_QUEUE, ua(CFP_U_QUEUE, k % 2));
    end
    // even units transmit; head moves on advance, tail on the engine
    for (int u = CFP_U_FIFO1; u < CFP_UNITS; u++)
    begin
      wr(CFP_CFG_OFF + 6'(u), {8'h01, ~1'(u), 7'h00});
      wr(CFP_CTL_OFF + 6'(u), 16'h0100);
      rd_ua(u, ua(u, (u % 2 == 0) ? 1 : 0));
      step(u, 2'(u));
      rd_ua(u, ua(u, (u % 2 == 0) ? 1 : 0));
    end
    @(posedge clk_sys);
    reset <= 1'b1;
    @(posedge clk_sys);
    reset <= 1'b0;
    base = 32'h0;
    reset_rows();
    results();
  end
endmodule // tb
